// [stc_pkg.sv]
// Package: register map, field layout and types of the 16-bit timer/counter
package stc_pkg;

    // Register offsets on the plain register port
    localparam logic [7:0] STC_OFF_CONTROL = 8'h10;
    localparam logic [7:0] STC_OFF_COUNT_LOW = 8'h0e;
    localparam logic [7:0] STC_OFF_COUNT_HIGH = 8'h0f;
    localparam logic [7:0] STC_OFF_FLAG = 8'h0c;
    localparam logic [7:0] STC_OFF_ENABLE = 8'h8c;

    // Control register field positions; flag bit of the flag and enable registers
    localparam int STC_BIT_ON = 0;
    localparam int STC_BIT_CS = 1;
    localparam int STC_BIT_SYNC_N = 2;
    localparam int STC_BIT_OSC_EN = 3;
    localparam int STC_BIT_PS_LO = 4;
    localparam int STC_BIT_RUN = 6;
    localparam int STC_BIT_FLAG = 0;

    // Values after reset, and the count value that wraps
    localparam logic [5:0] STC_CONTROL_RST = 6'h00;
    localparam logic [2:0] STC_PRESC_RST = 3'h0;
    localparam logic [1:0] STC_PHASE_RST = 2'h0;
    localparam logic [15:0] STC_COUNT_WRAP = 16'hffff;

    // System clock select code meaning "this oscillator drives the core"
    localparam logic [1:0] STC_SCS_LP_OSC = 2'h1;

    // Instruction cycle is four oscillator cycles
    localparam int STC_CLK_PER_INSTR = 4;

    // Prescale ratios
    typedef enum logic [1:0] {
        STC_DIV1 = 2'b00,
        STC_DIV2 = 2'b01,
        STC_DIV4 = 2'b10,
        STC_DIV8 = 2'b11
    } stc_prescale_t;

    // Software-visible control fields
    typedef struct packed {
        stc_prescale_t prescale_select;
        logic lp_osc_enable;
        logic sync_disable_n;
        logic clock_source_select;
        logic count_on;
    } stc_control_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } stc_bus_req_t;

endpackage : stc_pkg

// [stc_prescaler.sv]
// Prescaler: divides selected count edges by 1, 2, 4 or 8
`timescale 1ns/1ps
`default_nettype none
module stc_prescaler
    import stc_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic clear_in,
    input wire logic edge_in,
    input wire stc_prescale_t ratio_in,
    output logic tick_out
);
    logic [2:0] div_r;
    logic [2:0] div_nxt;

    // Division counter; advances on every edge, sleep or not
    always_comb begin
        div_nxt = div_r + 3'h1;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in || clear_in) begin
            div_r <= STC_PRESC_RST;
        end else if (edge_in) begin
            div_r <= div_nxt;
        end
    end

    // Tick on the edge that completes the selected group of edges
    always_comb begin
        case (ratio_in)
            STC_DIV1: tick_out = edge_in;
            STC_DIV2: tick_out = edge_in && (div_r[0] == 1'b1);
            STC_DIV4: tick_out = edge_in && (div_r[1:0] == 2'h3);
            STC_DIV8: tick_out = edge_in && (div_r == 3'h7);
            default: tick_out = 1'b0;
        endcase
    end
endmodule // stc_prescaler
`default_nettype wire

// [stc_edge_det.sv]
// Edge detector: rising and falling pulses of a sampled input
`timescale 1ns/1ps
`default_nettype none
module stc_edge_det (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic level_in,
    output logic rise_out,
    output logic fall_out
);
    logic last_r;

    // Previous level, held so both edges show as one-cycle pulses
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            last_r <= 1'b0;
        end else begin
            last_r <= level_in;
        end
    end

    assign rise_out = level_in && !last_r;
    assign fall_out = !level_in && last_r;
endmodule // stc_edge_det
`default_nettype wire

// [stc_timer.sv]
// 16-bit timer/counter with prescaler, clock source select and LP oscillator
// What this block does
// - Sixteen-bit count wraps all ones to zero
// - Wrap sets overflow flag; enable gates request
// - Timer mode advances once per instruction cycle
// - Counter mode advances on external rising edges
// - Source select bit chooses external or internal
// - On bit enables counting; clear holds count
// - After enable, wait for falling edge first
// - Oscillator enable picks oscillator input pin
// - Sync bit clear synchronises, set bypasses
// - Internal clock ignores the sync bit
// - Prescaler sits ahead of the synchroniser
// - Synced counter halts in sleep; prescaler runs
// - Prescale field selects divide by 1,2,4,8
// - Oscillator on forces pins input, read zero
// - Status bit shows oscillator drives system clock
// - Status follows actual source after oscillator failure
// - Special event trigger clears the count
// - Power-on reset clears control; count kept
// - Count byte write clears prescaler
// - Write beats simultaneous special event reset
`timescale 1ns/1ps
`default_nettype none
module stc_timer
    import stc_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic ext_count_pin_in,
    input wire logic osc_in_pin_in,
    input wire logic sleep_in,
    input wire logic [1:0] system_clock_select_in,
    input wire logic lp_osc_failed_in,
    input wire logic special_event_in,
    input wire logic [1:0] port_direction_in,
    input wire logic [1:0] port_pin_in,
    output logic [1:0] port_read_out,
    output logic [1:0] port_drive_en_out,
    output logic osc_inverter_en_out,
    output logic overflow_irq_out,
    output logic overflow_flag_out
);
    stc_bus_req_t req;
    stc_control_t ctrl_r;
    logic [7:0] count_low_byte_r;
    logic [7:0] count_high_byte_r;
    logic [15:0] count_pair;
    logic [15:0] count_pair_nxt;
    logic overflow_flag_r;
    logic overflow_irq_enable_r;
    logic [7:0] rdata_r;
    logic [1:0] phase_r;
    logic instr_tick;
    logic ext_level;
    logic ext_rise;
    logic ext_fall;
    logic armed_r;
    logic count_edge;
    logic presc_tick;
    logic presc_clear;
    logic sync_stage1_r;
    logic sync_stage2_r;
    logic sync_tick;
    logic inc_tick;
    logic wr_low;
    logic wr_high;
    logic wrap;
    logic osc_status;

    assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
    assign count_pair = {count_high_byte_r, count_low_byte_r};
    assign wr_low = req.wr && (req.addr == STC_OFF_COUNT_LOW);
    assign wr_high = req.wr && (req.addr == STC_OFF_COUNT_HIGH);

    // Control register; only reset_in (power-on/brown-out) clears it
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ctrl_r <= stc_control_t'(STC_CONTROL_RST);
        end else if (req.wr && req.addr == STC_OFF_CONTROL) begin
            ctrl_r <= stc_control_t'(req.wdata[5:0]);
        end
    end

    // Instruction clock: one enable pulse every four oscillator cycles
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            phase_r <= STC_PHASE_RST;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end
    assign instr_tick = (phase_r == 2'(STC_CLK_PER_INSTR - 1));

    // Oscillator pin replaces the clock pin when the oscillator runs
    assign ext_level = ctrl_r.lp_osc_enable ? osc_in_pin_in
                                            : ext_count_pin_in;

    stc_edge_det u_edge (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .level_in(ext_level),
        .rise_out(ext_rise),
        .fall_out(ext_fall)
    );

    // Arming: after enable in counter mode, a falling edge must come first
    always_ff @(posedge clk_in) begin
        if (reset_in || !ctrl_r.count_on || !ctrl_r.clock_source_select) begin
            armed_r <= 1'b0;
        end else if (ext_fall) begin
            armed_r <= 1'b1;
        end
    end

    // Source select feeds the prescaler; prescaler sees raw edges
    always_comb begin
        if (ctrl_r.clock_source_select) begin
            count_edge = ext_rise && armed_r;
        end else begin
            count_edge = instr_tick && ctrl_r.count_on;
        end
    end

    // Writing either count byte restarts the division
    assign presc_clear = wr_low || wr_high;

    stc_prescaler u_presc (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .clear_in(presc_clear),
        .edge_in(count_edge),
        .ratio_in(ctrl_r.prescale_select),
        .tick_out(presc_tick)
    );

    // Synchroniser on the prescaler output; held off in sleep
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sync_stage1_r <= 1'b0;
            sync_stage2_r <= 1'b0;
        end else if (!sleep_in) begin
            sync_stage1_r <= presc_tick;
            sync_stage2_r <= sync_stage1_r;
        end else begin
            sync_stage1_r <= 1'b0;
            sync_stage2_r <= 1'b0;
        end
    end
    assign sync_tick = sync_stage2_r;

    // Path choice: internal ignores the sync bit, async bypasses the stages
    always_comb begin
        if (!ctrl_r.clock_source_select) begin
            inc_tick = presc_tick;
        end else if (ctrl_r.sync_disable_n) begin
            inc_tick = presc_tick;
        end else begin
            inc_tick = sync_tick;
        end
        inc_tick = inc_tick && ctrl_r.count_on;
    end

    assign count_pair_nxt = count_pair + 16'h0001;
    assign wrap = inc_tick && (count_pair == STC_COUNT_WRAP);

    // Count bytes: write beats trigger beats increment; reset leaves them
    always_ff @(posedge clk_in) begin
        if (wr_low || wr_high) begin
            if (wr_low) begin
                count_low_byte_r <= req.wdata;
            end
            if (wr_high) begin
                count_high_byte_r <= req.wdata;
            end
        end else if (special_event_in) begin
            count_low_byte_r <= 8'h00;
            count_high_byte_r <= 8'h00;
        end else if (inc_tick) begin
            count_low_byte_r <= count_pair_nxt[7:0];
            count_high_byte_r <= count_pair_nxt[15:8];
        end
    end

    // Overflow flag: hardware set wins over a software clear
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            overflow_flag_r <= 1'b0;
        end else if (wrap) begin
            overflow_flag_r <= 1'b1;
        end else if (req.wr && req.addr == STC_OFF_FLAG) begin
            overflow_flag_r <= req.wdata[STC_BIT_FLAG];
        end
    end

    // Interrupt enable bit
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            overflow_irq_enable_r <= 1'b0;
        end else if (req.wr && req.addr == STC_OFF_ENABLE) begin
            overflow_irq_enable_r <= req.wdata[STC_BIT_FLAG];
        end
    end

    assign overflow_flag_out = overflow_flag_r;
    assign overflow_irq_out = overflow_flag_r && overflow_irq_enable_r;

    // Status follows the actual core clock, so a failed oscillator drops it
    assign osc_status = (system_clock_select_in == STC_SCS_LP_OSC)
                        && !lp_osc_failed_in;

    // Oscillator inverter powered only while enabled
    assign osc_inverter_en_out = ctrl_r.lp_osc_enable;

    // Oscillator pins become inputs reading zero; else direction rules
    assign port_drive_en_out = ctrl_r.lp_osc_enable ? 2'b00
                                                    : ~port_direction_in;
    assign port_read_out = ctrl_r.lp_osc_enable ? 2'b00 : port_pin_in;

    // Read data registered; unmapped addresses read zero
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rdata_r <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                STC_OFF_CONTROL: rdata_r <= {1'b0, osc_status, ctrl_r};
                STC_OFF_COUNT_LOW: rdata_r <= count_low_byte_r;
                STC_OFF_COUNT_HIGH: rdata_r <= count_high_byte_r;
                STC_OFF_FLAG: rdata_r <= {7'h00, overflow_flag_r};
                STC_OFF_ENABLE: rdata_r <= {7'h00, overflow_irq_enable_r};
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end
    assign rdata_out = rdata_r;
endmodule // stc_timer
`default_nettype wire

// [stc_timer_sva.sv]
// Checker: port-level assertions for the 16-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
module stc_timer_sva
    import stc_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic [1:0] system_clock_select_in,
    input wire logic lp_osc_failed_in,
    input wire logic [1:0] port_read_out,
    input wire logic [1:0] port_drive_en_out,
    input wire logic osc_inverter_en_out,
    input wire logic overflow_irq_out,
    input wire logic overflow_flag_out
);
    logic [5:0] ctl_r;
    logic en_r;
    logic [7:0] exp_r;
    logic flag_wr;
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    assign flag_wr = wr_in && addr_in == STC_OFF_FLAG;
    // Shadow of the writable control bits, known after reset only
    always_ff @(posedge clk_in) begin
        if (reset_in) ctl_r <= 6'h00;
        else if (wr_in && addr_in == STC_OFF_CONTROL) ctl_r <= wdata_in[5:0];
    end
    // Shadow of the overflow enable bit
    always_ff @(posedge clk_in) begin
        if (reset_in) en_r <= 1'b0;
        else if (wr_in && addr_in == STC_OFF_ENABLE) en_r <= wdata_in[0];
    end
    // Control read value as seen at the read strobe
    always_ff @(posedge clk_in) begin
        exp_r <= {1'b0, system_clock_select_in == STC_SCS_LP_OSC &&
            !lp_osc_failed_in, ctl_r};
    end
    sequence s_rd_ctrl;
        rd_in && addr_in == STC_OFF_CONTROL;
    endsequence
    sequence s_ctrl_back;
        rdata_out == exp_r;
    endsequence
    a_ctrl_read: assert property (s_rd_ctrl |=> s_ctrl_back)
        else $error("control readback differs");
    a_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data not idle");
    a_inv_follow: assert property (osc_inverter_en_out == ctl_r[3])
        else $error("inverter enable wrong");
    a_pins_input: assert property (ctl_r[3] |->
        port_drive_en_out == 2'b00 && port_read_out == 2'b00)
        else $error("oscillator pins not inputs");
    a_irq_gate: assert property (
        overflow_irq_out == (overflow_flag_out && en_r))
        else $error("request not flag and enable");
    a_flag_set: assert property (flag_wr && wdata_in[0] |=>
        overflow_flag_out)
        else $error("flag write lost");
    a_flag_keep: assert property (overflow_flag_out && !flag_wr |=>
        overflow_flag_out)
        else $error("flag dropped by itself");
    a_rst_clear: assert property ($fell(reset_in) |->
        !overflow_flag_out && !osc_inverter_en_out && !overflow_irq_out)
        else $error("state not cleared by reset");
endmodule // stc_timer_sva
`default_nettype wire

// [stc_clk_src.sv]
// Partner: external clock source and crystal at the count pins
`timescale 1ns/1ps
`default_nettype none
module stc_clk_src #(
    parameter int HALF_NS = 103
) (
    output logic ext_out,
    output logic osc_out
);
    // Both pins rest low, so a burst opens with a rise
    initial begin
        ext_out = 1'b0;
        osc_out = 1'b0;
    end
    // Full pulses on one pin, unrelated in phase to the core clock
    task automatic burst(input logic on_osc, input int n);
        for (int i = 0; i < n; i++) begin
            #(HALF_NS) {osc_out, ext_out} = on_osc ? 2'b10 : 2'b01;
            #(HALF_NS) {osc_out, ext_out} = 2'b00;
        end
    endtask
endmodule // stc_clk_src
`default_nettype wire

// [stc_timer_tb_top.sv]
// Testbench top: registers, count pins and trigger, with queued checks
`timescale 1ns/1ps
`default_nettype none
module stc_timer_tb_top
    import stc_pkg::*;
();
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic sleep_in = 1'b0;
    logic lp_osc_failed_in = 1'b0;
    logic special_event_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic [1:0] system_clock_select_in = 2'h0;
    logic [1:0] port_direction_in = 2'h0;
    logic [1:0] port_pin_in = 2'h0;
    logic [7:0] rdata_out;
    logic [1:0] port_read_out;
    logic [1:0] port_drive_en_out;
    logic osc_inverter_en_out, overflow_irq_out, overflow_flag_out;
    logic ext_pin, osc_pin;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] ctl_tab[5] = '{8'h03, 8'h07, 8'h0b, 8'h03, 8'h03};
    logic [7:0] cnt_tab[5] = '{8'h04, 8'h04, 8'h04, 8'h00, 8'h00};
    int num_errors = 0;
    int samples_checked = 0;
    int seed = 32'hfc5a;
    stc_timer DUT (.clk_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in,
        .rdata_out, .ext_count_pin_in(ext_pin), .osc_in_pin_in(osc_pin),
        .sleep_in, .system_clock_select_in, .lp_osc_failed_in,
        .special_event_in, .port_direction_in, .port_pin_in, .port_read_out,
        .port_drive_en_out, .osc_inverter_en_out, .overflow_irq_out,
        .overflow_flag_out);
    stc_clk_src src (.ext_out(ext_pin), .osc_out(osc_pin));
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end
    // Port pins wander randomly so the pin masking is exercised
    always @(posedge clk_in) begin
        port_pin_in <= 2'($random(seed));
        port_direction_in <= 2'($random(seed));
    end
    task automatic results();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk_rd(input logic [7:0] got);
        logic [7:0] e;
        e = exp_q.pop_front();
        samples_checked++;
        if (got !== e) begin
            num_errors++;
            $display("unexpected at %0t: read %h want %h", $time, got, e);
        end
    endtask
    task automatic chk_bit(input logic got, input logic e);
        samples_checked++;
        if (got !== e) begin
            num_errors++;
            $display("unexpected at %0t: level %b", $time, got);
        end
    endtask
    // Read data stands only in the cycle after the strobe
    always @(posedge clk_in) rd_seen <= rd_in;
    always @(negedge clk_in) if (rd_seen) chk_rd(rdata_out);
    // Trigger rides along so a write and a reset can coincide
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
        input logic t = 1'b0);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        special_event_in <= t;
        @(posedge clk_in);
        wr_in <= 1'b0;
        special_event_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        exp_q.push_back(e);
        @(posedge clk_in);
        rd_in <= 1'b0;
    endtask
    task automatic ld(input logic [15:0] v);
        wr(STC_OFF_COUNT_LOW, v[7:0]);
        wr(STC_OFF_COUNT_HIGH, v[15:8]);
    endtask
    task automatic ck(input logic [15:0] v);
        rd(STC_OFF_COUNT_LOW, v[7:0]);
        rd(STC_OFF_COUNT_HIGH, v[15:8]);
    endtask
    // Two write edges exactly n cycles apart: n/4 instruction ticks
    task automatic run(input logic [7:0] c, input int n);
        wr(STC_OFF_CONTROL, c);
        repeat (n - 2) @(posedge clk_in);
        wr(STC_OFF_CONTROL, 8'h00);
    endtask
    initial begin
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(STC_OFF_CONTROL, 8'h00);
        rd(8'h11, 8'h00);
        system_clock_select_in <= STC_SCS_LP_OSC;
        wr(STC_OFF_CONTROL, 8'hf0);
        rd(STC_OFF_CONTROL, 8'h70);
        lp_osc_failed_in <= 1'b1;
        rd(STC_OFF_CONTROL, 8'h30);
        $display("registers done");
        for (int p = 0; p < 4; p++) begin
            ld(16'h0000);
            run({2'b00, 2'(p), 1'b0, 1'(p), 2'b01}, 32);
            ck(16'(8 >> p));
        end
        // Leave the divide-by-8 counter at five, then prove a write clears it
        ld(16'h0000);
        run(8'h31, 20);
        ld(16'h0000);
        run(8'h31, 28);
        ck(16'h0000);
        $display("prescale done");
        ld(16'hfffe);
        run(8'h01, 8);
        ck(16'h0000);
        rd(STC_OFF_FLAG, 8'h01);
        @(negedge clk_in);
        chk_bit(overflow_irq_out, 1'b0);
        wr(STC_OFF_ENABLE, 8'h01);
        @(negedge clk_in);
        chk_bit(overflow_irq_out, 1'b1);
        wr(STC_OFF_FLAG, 8'h00);
        @(negedge clk_in);
        chk_bit(overflow_irq_out, 1'b0);
        // Software may also set the flag, which raises the request
        wr(STC_OFF_FLAG, 8'h01);
        rd(STC_OFF_FLAG, 8'h01);
        @(negedge clk_in);
        chk_bit(overflow_irq_out, 1'b1);
        wr(STC_OFF_FLAG, 8'h00);
        ld(16'h1234);
        wr(8'h00, 8'h5a, 1'b1);
        ck(16'h0000);
        wr(STC_OFF_COUNT_LOW, 8'h77, 1'b1);
        rd(STC_OFF_COUNT_LOW, 8'h77);
        // Mid-run reset: control must clear, the count must survive
        wr(STC_OFF_CONTROL, 8'h3c);
        reset_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(STC_OFF_CONTROL, 8'h00);
        rd(STC_OFF_COUNT_LOW, 8'h77);
        $display("overflow and trigger done");
        for (int i = 0; i < 5; i++) begin
            ld(16'h0000);
            sleep_in <= i == 4;
            wr(STC_OFF_CONTROL, ctl_tab[i]);
            src.burst(i == 2 || i == 3, 5);
            repeat (8) @(posedge clk_in);
            wr(STC_OFF_CONTROL, 8'h00);
            sleep_in <= 1'b0;
            rd(STC_OFF_COUNT_LOW, cnt_tab[i]);
        end
        repeat (2) @(posedge clk_in);
        $display("counter modes done");
        results();
    end
    // Whole run is about six hundred cycles; this bound cuts a hang short
    initial begin
        #200000;
        num_errors++;
        results();
    end
endmodule // stc_timer_tb_top
bind stc_timer stc_timer_sva u_sva (.clk_in, .reset_in, .addr_in, .wdata_in,
    .wr_in, .rd_in, .rdata_out, .system_clock_select_in, .lp_osc_failed_in,
    .port_read_out, .port_drive_en_out, .osc_inverter_en_out,
    .overflow_irq_out, .overflow_flag_out);
`default_nettype wire
